//--- core/option_bus_defines.svh
// constants shared by both ends of the expansion bus
`ifndef OPTION_BUS_DEFINES_SVH
`define OPTION_BUS_DEFINES_SVH
`define ADDR_W 20
`define DATA_W 16
`define IO_ADDR_W 16
`define LANE_W 8
`define REQ_CHANNELS 3
`define MAX_MASTERS 4
`define IRQ_LEVELS 7
`define BANK_W 4
`define BANK_OFS_W 16
`endif

//--- core/option_bus_pkg.sv
// types shared by both ends of the expansion bus
`include "option_bus_defines.svh"
package option_bus_pkg;
    typedef enum logic [1:0] {
        OWNER_MAIN = 2'b00,
        OWNER_OPT0 = 2'b01,
        OWNER_OPT1 = 2'b11,
        OWNER_OPT2 = 2'b10
    } owner_e;
    typedef enum logic [1:0] {
        ACC_EVEN = 2'b00,
        ACC_ODD = 2'b01,
        ACC_WORD = 2'b10,
        ACC_RSVD = 2'b11
    } access_e;
    function automatic access_e lane_decode(input logic upper, input logic a0);
        return access_e'({upper, a0});
    endfunction
endpackage

//--- core/option_bus_if.sv
// expansion bus wires between the main board and one option board
`include "option_bus_defines.svh"
interface option_bus_if;
    logic [`ADDR_W-1:0] addr_main;
    logic [`ADDR_W-1:0] addr_opt;
    logic addr_opt_oe;
    logic [`DATA_W-1:0] data_main;
    logic data_main_oe;
    logic [`DATA_W-1:0] data_opt;
    logic data_opt_oe;
    logic upper_main;
    logic upper_opt;
    logic mio_main;
    logic mio_opt;
    logic expansion_addr_latch_strobe;
    logic write_main;
    logic write_opt;
    logic active_main;
    logic active_opt;
    logic [`REQ_CHANNELS-1:0] master_request_line;
    logic [`REQ_CHANNELS-1:0] master_grant_line;
    logic [`IRQ_LEVELS-1:0] irq_level;
    wire [`ADDR_W-1:0] addr_bus = addr_opt_oe ? addr_opt : addr_main;
    wire [`DATA_W-1:0] data_bus = data_opt_oe ? data_opt : (data_main_oe ? data_main : '0);
    // the option board owns the cycle-qualifying lines while it drives the address
    wire upper_byte_lane_enable = addr_opt_oe ? upper_opt : upper_main;
    wire memory_or_io_select = addr_opt_oe ? mio_opt : mio_main;
    wire cycle_write = addr_opt_oe ? write_opt : write_main;
    wire cycle_active = addr_opt_oe ? active_opt : active_main;
    modport main_end(
        output addr_main, data_main, data_main_oe, expansion_addr_latch_strobe,
        output master_grant_line, upper_main, mio_main, write_main, active_main,
        input addr_bus, data_bus, addr_opt_oe, data_opt_oe, master_request_line, irq_level,
        input upper_byte_lane_enable, memory_or_io_select, cycle_write, cycle_active
    );
    modport option_end(
        output addr_opt, addr_opt_oe, data_opt, data_opt_oe, master_request_line, irq_level,
        output upper_opt, mio_opt, write_opt, active_opt,
        input addr_bus, data_bus, master_grant_line, expansion_addr_latch_strobe,
        input data_main_oe
    );
endinterface

//--- core/option_bus_main.sv
// main board end: bus buffers, arbiter and cpu access path
`include "option_bus_defines.svh"
module option_bus_main
    import option_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    option_bus_if.main_end bus,
    input wire logic cpu_req,
    input wire logic cpu_secondary,
    input wire logic cpu_io,
    input wire logic cpu_write,
    input wire logic [`ADDR_W-1:0] cpu_addr,
    input wire logic [`BANK_W-1:0] cpu_bank,
    input wire logic [`LANE_W-1:0] cpu_wdata,
    output logic [`LANE_W-1:0] cpu_rdata,
    output logic cpu_done,
    output logic cpu_refused,
    output logic [`ADDR_W-1:0] mem_addr,
    output logic [`DATA_W-1:0] mem_wdata,
    output logic mem_write,
    output logic mem_strobe,
    input wire logic [`LANE_W-1:0] mem_rdata,
    output logic [`IRQ_LEVELS-1:0] irq_pending,
    output logic [1:0] bus_owner
);
    // ************************************
    // arbiter
    // ************************************
    owner_e owner;
    owner_e next_owner;
    always_comb begin
        next_owner = owner;
        case (owner)
            OWNER_MAIN: begin
                // fixed priority, channel 0 highest
                if (bus.master_request_line[0] && !bus.cycle_active) begin
                    next_owner = OWNER_OPT0;
                end else if (bus.master_request_line[1] && !bus.cycle_active) begin
                    next_owner = OWNER_OPT1;
                end else if (bus.master_request_line[2] && !bus.cycle_active) begin
                    next_owner = OWNER_OPT2;
                end
            end
            OWNER_OPT0: if (!bus.master_request_line[0]) next_owner = OWNER_MAIN;
            OWNER_OPT1: if (!bus.master_request_line[1]) next_owner = OWNER_MAIN;
            OWNER_OPT2: if (!bus.master_request_line[2]) next_owner = OWNER_MAIN;
            default: next_owner = OWNER_MAIN;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) owner <= OWNER_MAIN;
        else if (clk_en) owner <= next_owner;
    end

    // ************************************
    // main board master cycles
    // ************************************
    logic [`LANE_W-1:0] next_cpu_rdata;
    logic next_done;
    logic next_refused;
    logic [`ADDR_W-1:0] next_addr;
    logic [`DATA_W-1:0] next_wdata;
    logic next_oe;
    logic next_strobe;
    logic next_mio;
    logic next_wr;
    logic next_act;
    logic [`ADDR_W-1:0] cyc_addr;
    logic [`DATA_W-1:0] cyc_wdata;
    logic cyc_oe;
    logic cyc_strobe;
    logic cyc_mio;
    logic cyc_wr;
    logic cyc_act;
    logic [`ADDR_W-1:0] eff_addr;
    always_comb begin
        // secondary cpu reaches memory through a bank register only
        if (cpu_secondary) begin
            eff_addr = {cpu_bank, cpu_addr[`BANK_OFS_W-1:0]};
        end else if (cpu_io) begin
            eff_addr = {{(`ADDR_W-`IO_ADDR_W){1'b0}}, cpu_addr[`IO_ADDR_W-1:0]};
        end else begin
            eff_addr = cpu_addr;
        end
    end
    always_comb begin
        next_cpu_rdata = cpu_rdata;
        next_done = 1'b0;
        next_refused = 1'b0;
        next_addr = cyc_addr;
        next_wdata = cyc_wdata;
        next_oe = 1'b0;
        next_strobe = 1'b0;
        next_mio = cyc_mio;
        next_wr = cyc_wr;
        next_act = 1'b0;
        if (cyc_act) begin
            // single-cycle data phase: no wait state inserted here
            next_done = 1'b1;
            if (!cyc_wr) next_cpu_rdata = bus.data_bus[`LANE_W-1:0];
        end else if (cpu_req && owner == OWNER_MAIN && next_owner == OWNER_MAIN) begin
            if (cpu_io && cpu_secondary) begin
                next_refused = 1'b1;
            end else begin
                next_act = 1'b1;
                next_strobe = !cpu_secondary;
                next_addr = eff_addr;
                next_mio = !cpu_io;
                next_wr = cpu_write;
                next_wdata = {{(`DATA_W-`LANE_W){1'b0}}, cpu_wdata};
                next_oe = cpu_write;
            end
        end else if (cpu_req && owner != OWNER_MAIN) begin
            next_refused = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_rdata <= '0;
            cpu_done <= 1'b0;
            cpu_refused <= 1'b0;
            cyc_addr <= '0;
            cyc_wdata <= '0;
            cyc_oe <= 1'b0;
            cyc_strobe <= 1'b0;
            cyc_mio <= 1'b1;
            cyc_wr <= 1'b0;
            cyc_act <= 1'b0;
        end else if (clk_en) begin
            cpu_rdata <= next_cpu_rdata;
            cpu_done <= next_done;
            cpu_refused <= next_refused;
            cyc_addr <= next_addr;
            cyc_wdata <= next_wdata;
            cyc_oe <= next_oe | (next_done & cyc_oe);
            cyc_strobe <= next_strobe;
            cyc_mio <= next_mio;
            cyc_wr <= next_wr;
            cyc_act <= next_act;
        end
    end
    // write data stays on the bus through the data phase
    always_comb begin
        bus.addr_main = cyc_addr;
        // under option mastership the lower lane returns main memory read data
        bus.data_main = (owner == OWNER_MAIN) ? cyc_wdata
            : {{(`DATA_W-`LANE_W){1'b0}}, mem_rdata};
        // under option mastership driven only while mem_strobe is set for a main memory read (mem_write low), otherwise released
        bus.data_main_oe = (owner == OWNER_MAIN) ? cyc_oe : (mem_strobe & !mem_write);
        bus.expansion_addr_latch_strobe = cyc_strobe;
        bus.master_grant_line[0] = (owner == OWNER_OPT0);
        bus.master_grant_line[1] = (owner == OWNER_OPT1);
        bus.master_grant_line[2] = (owner == OWNER_OPT2);
        // main cycles are byte wide; the option side takes these lines over while it drives
        bus.upper_main = 1'b0;
        bus.mio_main = cyc_mio;
        bus.write_main = cyc_wr;
        bus.active_main = cyc_act;
    end

    // ************************************
    // option board master into main memory
    // ************************************
    logic [`ADDR_W-1:0] next_mem_addr;
    logic [`DATA_W-1:0] next_mem_wdata;
    logic next_mem_write;
    logic next_mem_strobe;
    logic [`IRQ_LEVELS-1:0] next_irq;
    always_comb begin
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_mem_write = mem_write;
        next_mem_strobe = 1'b0;
        // address taken from the option side under option mastership
        if (owner != OWNER_MAIN && bus.addr_opt_oe && bus.cycle_active
            && bus.memory_or_io_select && !bus.upper_byte_lane_enable) begin
            next_mem_addr = bus.addr_bus;
            next_mem_wdata = bus.data_bus;
            next_mem_write = bus.cycle_write;
            next_mem_strobe = 1'b1;
        end
        next_irq = bus.irq_level;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_addr <= '0;
            mem_wdata <= '0;
            mem_write <= 1'b0;
            mem_strobe <= 1'b0;
            irq_pending <= '0;
            bus_owner <= 2'b00;
        end else if (clk_en) begin
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            mem_write <= next_mem_write;
            mem_strobe <= next_mem_strobe;
            irq_pending <= next_irq;
            bus_owner <= next_owner;
        end
    end
endmodule

//--- core/option_bus_option.sv
// option board end: bus master on one request channel with 16/8-bit transfers, no memory slave logic
`include "option_bus_defines.svh"
module option_bus_option
    import option_bus_pkg::*;
#(
    parameter int CHANNEL = 0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    option_bus_if.option_end bus,
    input wire logic want_bus,
    input wire logic [`ADDR_W-1:0] req_addr,
    input wire logic req_word,
    input wire logic req_write,
    input wire logic [`DATA_W-1:0] req_wdata,
    input wire logic [`IRQ_LEVELS-1:0] irq_raise,
    output logic granted,
    output logic [`DATA_W-1:0] rd_data
);
    // ************************************
    // mastership and drive
    // ************************************
    logic next_req;
    logic req_q;
    logic [`ADDR_W-1:0] next_a;
    logic [`ADDR_W-1:0] a_q;
    logic next_aoe;
    logic aoe_q;
    logic [`DATA_W-1:0] next_d;
    logic [`DATA_W-1:0] d_q;
    logic next_doe;
    logic doe_q;
    logic next_word;
    logic word_q;
    logic next_granted;
    logic [`DATA_W-1:0] next_rd;
    logic [`IRQ_LEVELS-1:0] irq_q;
    logic [`DATA_W-1:0] wmem [0:15];
    always_comb begin
        next_req = want_bus;
        next_granted = bus.master_grant_line[CHANNEL];
        next_aoe = 1'b0;
        next_a = a_q;
        next_d = d_q;
        next_doe = 1'b0;
        next_word = 1'b0;
        next_rd = rd_data;
        if (granted && bus.master_grant_line[CHANNEL] && want_bus) begin
            next_aoe = 1'b1;
            next_a = {req_addr[`ADDR_W-1:1], req_addr[0] & !req_word};
            next_d = req_word ? req_wdata : {8'h00, req_wdata[`LANE_W-1:0]};
            next_doe = req_write;
            next_word = req_word;
        end
        if (bus.data_main_oe) next_rd = bus.data_bus;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_q <= 1'b0;
            a_q <= '0;
            aoe_q <= 1'b0;
            d_q <= '0;
            doe_q <= 1'b0;
            word_q <= 1'b0;
            granted <= 1'b0;
            rd_data <= '0;
            irq_q <= '0;
        end else if (clk_en) begin
            req_q <= next_req;
            a_q <= next_a;
            aoe_q <= next_aoe;
            d_q <= next_d;
            doe_q <= next_doe;
            word_q <= next_word;
            granted <= next_granted;
            rd_data <= next_rd;
            irq_q <= irq_raise;
        end
    end
    always_comb begin
        bus.master_request_line = '0;
        bus.master_request_line[CHANNEL] = req_q;
        bus.addr_opt = a_q;
        bus.addr_opt_oe = aoe_q;
        bus.data_opt = d_q;
        bus.data_opt_oe = doe_q;
        // option masters run memory cycles only; a write is a cycle that drives data
        bus.upper_opt = word_q;
        bus.mio_opt = 1'b1;
        bus.write_opt = doe_q;
        bus.active_opt = aoe_q;
        bus.irq_level = irq_q;
    end
    // small local store of whole 16-bit words filled by its own master writes, slave side not modelled further
    always_ff @(posedge sys_clk) begin
        if (clk_en && aoe_q && doe_q) wmem[a_q[4:1]] <= d_q;
    end
endmodule

//--- test/option_bus_monitor.sv
// concurrent checks on the expansion bus wires between the two ends
`include "option_bus_defines.svh"
module option_bus_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [`ADDR_W-1:0] addr_bus,
    input wire logic [`DATA_W-1:0] data_main,
    input wire logic data_main_oe,
    input wire logic upper_byte_lane_enable,
    input wire logic memory_or_io_select,
    input wire logic expansion_addr_latch_strobe,
    input wire logic cycle_active,
    input wire logic [`REQ_CHANNELS-1:0] master_request_line,
    input wire logic [`REQ_CHANNELS-1:0] master_grant_line
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // arbitration
    // ****************************************
    a_one_grant: assert property ($onehot0(master_grant_line))
        else $error("more than one grant");
    a_grant_release: assert property (master_grant_line != '0 |-> !data_main_oe)
        else $error("main data driven under option mastership");
    a_grant_held: assert property ((master_grant_line & master_request_line) != '0
        |=> master_grant_line == $past(master_grant_line)) else $error("grant moved");
    a_grant_cause: assert property ((master_grant_line & ~$past(master_grant_line)) != '0
        |-> (master_grant_line & $past(master_request_line)) != '0)
        else $error("grant without request");
    a_prio_mid: assert property ($rose(master_grant_line[1])
        |-> !$past(master_request_line[0])) else $error("channel one beat channel zero");
    a_prio_low: assert property ($rose(master_grant_line[2])
        |-> $past(master_request_line[1:0]) == 2'b00) else $error("channel two out of turn");
    a_grant_idle: assert property ($rose(|master_grant_line) |-> !$past(cycle_active))
        else $error("grant during active cycle");
    // ****************************************
    // cycle shape
    // ****************************************
    a_main_lane: assert property (data_main_oe |-> data_main[15:8] == 8'h00)
        else $error("main drove upper lane");
    a_word_even: assert property (cycle_active && upper_byte_lane_enable |-> !addr_bus[0])
        else $error("word transfer at odd address");
    a_memio_stable: assert property ($fell(expansion_addr_latch_strobe)
        |-> $stable(memory_or_io_select)) else $error("memory or io moved at strobe end");
    a_no_wait: assert property (expansion_addr_latch_strobe |-> ##[1:2] !cycle_active)
        else $error("main cycle stretched");
    cover property ($rose(master_grant_line[0]));
    cover property ($fell(expansion_addr_latch_strobe));
    cover property (data_main_oe ##1 !data_main_oe);
endmodule

//--- test/option_bus_interface_tb.sv
// self-checking bench joining the main board end to one option board end
`include "option_bus_defines.svh"
module option_bus_interface_tb;
    import option_bus_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst = 1, clk_en = 1;
    logic cpu_req = 0, cpu_secondary = 0, cpu_io = 0, cpu_write = 0;
    logic [19:0] cpu_addr = '0, mem_addr, req_addr = '0, cap_addr;
    logic [3:0] cpu_bank = '0;
    logic [7:0] cpu_wdata = '0, cpu_rdata, mem_rdata = 8'h3C;
    logic cpu_done, cpu_refused, mem_write, mem_strobe, granted;
    logic [15:0] mem_wdata, rd_data, req_wdata = '0, cap_data;
    logic want_bus = 0, req_word = 0, req_write = 0;
    logic [6:0] irq_raise = '0, irq_pending;
    logic [1:0] bus_owner;
    logic saw_strobe, saw_drive, saw_act, saw_refused;
    int mismatches = 0, check_count = 0, cycles = 0, lat;
    always #10 sys_clk = ~sys_clk;
    option_bus_if u_option_bus_if();
    option_bus_main u_option_bus_main(.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .bus(u_option_bus_if.main_end), .cpu_req(cpu_req), .cpu_secondary(cpu_secondary),
        .cpu_io(cpu_io), .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_bank(cpu_bank),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_done(cpu_done),
        .cpu_refused(cpu_refused), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_write(mem_write), .mem_strobe(mem_strobe), .mem_rdata(mem_rdata),
        .irq_pending(irq_pending), .bus_owner(bus_owner));
    option_bus_option #(.CHANNEL(0)) u_option_bus_option(.sys_clk(sys_clk), .rst(rst),
        .clk_en(clk_en), .bus(u_option_bus_if.option_end), .want_bus(want_bus),
        .req_addr(req_addr), .req_word(req_word), .req_write(req_write),
        .req_wdata(req_wdata), .irq_raise(irq_raise), .granted(granted), .rd_data(rd_data));
    option_bus_monitor u_option_bus_monitor(.sys_clk(sys_clk), .rst(rst),
        .addr_bus(u_option_bus_if.addr_bus), .data_main(u_option_bus_if.data_main),
        .data_main_oe(u_option_bus_if.data_main_oe),
        .upper_byte_lane_enable(u_option_bus_if.upper_byte_lane_enable),
        .memory_or_io_select(u_option_bus_if.memory_or_io_select),
        .expansion_addr_latch_strobe(u_option_bus_if.expansion_addr_latch_strobe),
        .cycle_active(u_option_bus_if.cycle_active),
        .master_request_line(u_option_bus_if.master_request_line),
        .master_grant_line(u_option_bus_if.master_grant_line));
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge sys_clk);
        #2;
    endtask
    // one cpu access; records what the main end put on the wires
    task automatic cpu_cycle(input logic sec, io, wr, input logic [19:0] a, input logic [7:0] d);
        cpu_secondary = sec;
        cpu_io = io;
        cpu_write = wr;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_req = 1;
        lat = 0;
        saw_strobe = 0;
        saw_drive = 0;
        saw_act = 0;
        cap_addr = 'x;
        cap_data = 'x;
        while (!(cpu_done === 1'b1 || cpu_refused === 1'b1) && lat < 10) begin
            step();
            lat++;
            if (u_option_bus_if.expansion_addr_latch_strobe === 1'b1) saw_strobe = 1;
            if (u_option_bus_if.cycle_active === 1'b1) begin
                saw_act = 1;
                cap_addr = u_option_bus_if.addr_bus;
            end
            if (u_option_bus_if.data_main_oe === 1'b1) begin
                saw_drive = 1;
                cap_data = u_option_bus_if.data_bus;
            end
        end
        // refused stands only while cpu_req is held, so keep it while it stands
        saw_refused = (cpu_refused === 1'b1);
        cpu_req = 0;
        step();
    endtask
    task automatic t_reset();
        chk("owner", bus_owner, OWNER_MAIN);
        chk("granted", granted, 0);
        $display("test reset done");
    endtask
    task automatic t_cpu_primary();
        cpu_cycle(0, 0, 1, 20'hA5F3C, 8'h5A);
        chk("write latency", lat, 2);
        chk("write addr", cap_addr, 20'hA5F3C);
        chk("write data", cap_data, 16'h005A);
        chk("strobe", saw_strobe, 1);
        chk("option sees write", rd_data, 16'h005A);
        cpu_cycle(0, 0, 0, 20'h00011, 8'h00);
        chk("read latency", lat, 2);
        chk("read drive", saw_drive, 0);
        chk("read idle lane", cpu_rdata, 8'h00);
        $display("test primary done");
    endtask
    task automatic t_cpu_secondary();
        cpu_bank = 4'hB;
        cpu_cycle(1, 0, 1, 20'h34567, 8'hC3);
        chk("bank addr", cap_addr, 20'hB4567);
        chk("bank strobe", saw_strobe, 0);
        cpu_cycle(1, 1, 1, 20'h00300, 8'h11);
        chk("io refused", saw_refused, 1);
        chk("io no cycle", saw_act, 0);
        $display("test secondary done");
    endtask
    task automatic t_option_master();
        req_addr = 20'h12345;
        req_wdata = 16'hBEEF;
        req_write = 1;
        want_bus = 1;
        for (int i = 0; i < 20 && granted !== 1'b1; i++) step();
        chk("owner opt", bus_owner, OWNER_OPT0);
        chk("grant line", u_option_bus_if.master_grant_line, 3'b001);
        for (int i = 0; i < 20 && mem_strobe !== 1'b1; i++) step();
        chk("mem addr", mem_addr, 20'h12345);
        chk("mem write", mem_write, 1);
        chk("mem byte", mem_wdata[7:0], 8'hEF);
        cpu_cycle(0, 0, 1, 20'h00100, 8'h77);
        chk("cpu refused", saw_refused, 1);
        req_word = 1;
        req_addr = 20'h12347;
        req_wdata = 16'hCAFE;
        step();
        step();
        chk("word even", u_option_bus_if.addr_bus, 20'h12346);
        chk("word lanes", u_option_bus_if.data_bus, 16'hCAFE);
        chk("word to main", mem_strobe, 0);
        req_word = 0;
        want_bus = 0;
        for (int i = 0; i < 20 && granted !== 1'b0; i++) step();
        step();
        chk("owner back", bus_owner, OWNER_MAIN);
        $display("test option master done");
    endtask
    task automatic t_irq();
        irq_raise = 7'h55;
        for (int i = 0; i < 10 && irq_pending !== 7'h55; i++) step();
        chk("irq", irq_pending, 7'h55);
        clk_en = 0;
        irq_raise = 7'h2A;
        repeat (3) step();
        chk("irq frozen", irq_pending, 7'h55);
        clk_en = 1;
        for (int i = 0; i < 10 && irq_pending !== 7'h2A; i++) step();
        chk("irq thawed", irq_pending, 7'h2A);
        $display("test irq done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #2 rst = 0;
        step();
        t_reset();
        t_cpu_primary();
        t_cpu_secondary();
        t_option_master();
        t_irq();
        conclude();
    end
endmodule
